// file: lsad_pkg.sv
/*
  Shared constants, types and state layouts for the local SDRAM/SGRAM
  address decoder. Assumes a single memory clock and that the boundary
  and geometry inputs are held steady by configuration logic.

// Summary of operation
// - Drive 64-bit data path, SDRAM/SGRAM, 8 MB
// - 2 KB pages over two chip-select banks
// - Three geometries: 10/11/12 row, 8 column bits
// - Row phase maps A22..A11 onto address bus
// - Column phase carries A10..A3, upper bits zero
// - Issue CAS-before-RAS auto refresh commands
*/
package lsad_pkg;
  localparam int DATA_W = 64;
  localparam int LIN_W = 23;
  localparam int MA_W = 12;
  localparam int BND_W = 8;
  localparam logic [1:0] GEOM_ROW10 = 2'h0;
  localparam logic [1:0] GEOM_ROW11 = 2'h1;
  localparam logic [1:0] GEOM_ROW12 = 2'h2;
  localparam int MB_LSB = 20;
  localparam int REFRESH_INTERVAL_NS = 15600;
  localparam int CLK_PERIOD_NS = 20;
  localparam int REFRESH_CYCLES = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int REF_CNT_W = 10;
  localparam logic [REF_CNT_W-1:0] REF_CNT_RESET = 10'h000;

  typedef enum logic [1:0] {ST_IDLE, ST_ROW, ST_COL, ST_REF} lsad_state_e;

  typedef struct packed {
    logic [LIN_W-1:0] addr;
    logic write;
    logic [DATA_W-1:0] wdata;
  } lsad_req_s;

  typedef struct packed {
    logic [MA_W-1:0] addr;
    logic cs0_n;
    logic cs1_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
  } lsad_mem_s;

  localparam lsad_mem_s MEM_IDLE = '{addr: 12'h000, cs0_n: 1'b1,
    cs1_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
    dq: 64'h0000_0000_0000_0000, dq_oe: 1'b0};

  typedef struct packed {
    lsad_state_e st;
    lsad_req_s req;
    lsad_mem_s mem;
    logic ref_pending;
    logic ready;
  } lsad_top_s;

  typedef struct packed {
    logic [REF_CNT_W-1:0] count;
    logic due;
  } lsad_tmr_s;
endpackage : lsad_pkg

// file: lsad_refresh_timer.sv
/*
  Refresh interval timer: one-cycle pulse every REFRESH_CYCLES clocks.
  Assumes synchronous active-high reset on the memory clock.
*/
`timescale 1ns/100ps
`default_nettype none
module lsad_refresh_timer (
  input wire logic mclk,
  input wire logic reset,
  output logic refresh_due
);
  import lsad_pkg::*;

  localparam logic [REF_CNT_W-1:0] LAST =
    REF_CNT_W'(REFRESH_CYCLES - 1);

  lsad_tmr_s cur;
  lsad_tmr_s next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.due = 1'b0;
    if (cur.count == LAST) begin
      next_cur.count = REF_CNT_RESET;
      next_cur.due = 1'b1;
    end else begin
      next_cur.count = cur.count + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cur <= '{count: REF_CNT_RESET, due: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign refresh_due = cur.due;

  a_timer_period: assert property (
    @(posedge mclk) disable iff (reset) cur.due |-> ##1 (!cur.due [*8]))
    else $error("refresh pulse repeated too soon");
endmodule : lsad_refresh_timer
`default_nettype wire

// file: lsad_top.sv
/*
  Local memory address decoder: splits a linear address into row and
  column phases, selects one of two chip-select banks from the boundary
  inputs and interleaves auto refresh. Assumes requests, geometry and
  boundaries come from logic on mclk; no synchroniser is needed.
  Geometry code 3 decodes like the by-32 parts.
*/
`timescale 1ns/100ps
`default_nettype none
module lsad_top (
  input wire logic mclk,
  input wire logic reset,
  input wire lsad_pkg::lsad_req_s req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] geometry,
  input wire logic [lsad_pkg::BND_W-1:0] first_boundary_reg,
  input wire logic [lsad_pkg::BND_W-1:0] second_boundary_reg,
  output logic [lsad_pkg::MA_W-1:0] mem_addr_bus,
  output logic bank0_select_n,
  output logic bank1_select_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_enable_n,
  output logic [lsad_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe
);
  import lsad_pkg::*;

  lsad_top_s cur;
  lsad_top_s next_cur;
  logic refresh_due;

  // Timer restarts with reset, so a reset also delays the next refresh
  lsad_refresh_timer u_timer (
    .mclk(mclk),
    .reset(reset),
    .refresh_due(refresh_due)
  );

  function automatic logic [MA_W-1:0] row_addr(
    input logic [LIN_W-1:0] a, input logic [1:0] g);
    logic [MA_W-1:0] r;
    r = {a[11], a[22], a[21], a[20], a[19:12]};
    // By-16 parts need A11 low in the row, so the pair shifts down
    if (g == GEOM_ROW12) begin
      r[10] = a[21];
      r[9] = a[11];
    end
    return r;
  endfunction : row_addr

  function automatic logic [MA_W-1:0] col_addr(
    input logic [LIN_W-1:0] a);
    // Upper column bits carry no address; driven low for a quiet bus
    return {4'h0, a[10:3]};
  endfunction : col_addr

  // Returns {bank1 hit, bank0 hit}; whole megabytes compare exactly
  function automatic logic [1:0] bank_hit(
    input logic [LIN_W-1:0] a, input logic [BND_W-1:0] b0,
    input logic [BND_W-1:0] b1);
    logic [BND_W-1:0] mb;
    mb = {5'h00, a[LIN_W-1:MB_LSB]};
    // An empty bank repeats the boundary below it, so its range is empty
    if (mb < b0) begin
      return 2'h1;
    end else if (mb < b1) begin
      return 2'h2;
    end
    return 2'h0;
  endfunction : bank_hit

  always_comb begin
    logic [1:0] hit;
    hit = 2'h0;
    next_cur = cur;
    next_cur.mem = MEM_IDLE;
    next_cur.ref_pending = cur.ref_pending | refresh_due;
    case (cur.st)
      ST_IDLE: begin
        if (req_valid && cur.ready) begin
          hit = bank_hit(req.addr, first_boundary_reg,
            second_boundary_reg);
          next_cur.req = req;
          next_cur.st = ST_ROW;
          next_cur.mem.addr = row_addr(req.addr, geometry);
          next_cur.mem.cs0_n = !hit[0];
          next_cur.mem.cs1_n = !hit[1];
          next_cur.mem.ras_n = 1'b0;
        end else if (cur.ref_pending) begin
          next_cur.st = ST_REF;
          // A refresh pulse landing now stays pending: set wins
          next_cur.ref_pending = refresh_due;
          next_cur.mem.cs0_n = 1'b0;
          next_cur.mem.cs1_n = 1'b0;
          next_cur.mem.ras_n = 1'b0;
          next_cur.mem.cas_n = 1'b0;
        end
      end
      ST_ROW: begin
        // Same bank stays selected so the column hits the open page
        next_cur.st = ST_COL;
        next_cur.mem.addr = col_addr(cur.req.addr);
        next_cur.mem.cs0_n = cur.mem.cs0_n;
        next_cur.mem.cs1_n = cur.mem.cs1_n;
        next_cur.mem.cas_n = 1'b0;
        next_cur.mem.we_n = !cur.req.write;
        next_cur.mem.dq = cur.req.wdata;
        next_cur.mem.dq_oe = cur.req.write;
      end
      ST_COL: begin
        next_cur.st = ST_IDLE;
      end
      ST_REF: begin
        next_cur.st = ST_IDLE;
      end
      default: begin
        next_cur.st = ST_IDLE;
      end
    endcase
    // Ready falls the cycle after refresh is due, so later requests wait for the refresh
    next_cur.ready = (next_cur.st == ST_IDLE) && !next_cur.ref_pending;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cur <= '{st: ST_IDLE, req: '0, mem: MEM_IDLE, ref_pending: 1'b0,
        ready: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs come straight from the state register
  assign req_ready = cur.ready;
  assign mem_addr_bus = cur.mem.addr;
  assign bank0_select_n = cur.mem.cs0_n;
  assign bank1_select_n = cur.mem.cs1_n;
  assign row_strobe_n = cur.mem.ras_n;
  assign col_strobe_n = cur.mem.cas_n;
  assign write_enable_n = cur.mem.we_n;
  assign mem_data_out = cur.mem.dq;
  assign mem_data_oe = cur.mem.dq_oe;

  // Command decode used only by the checks below
  logic row_cmd;
  logic col_cmd;
  logic ref_cmd;
  assign row_cmd = !row_strobe_n && col_strobe_n;
  assign col_cmd = row_strobe_n && !col_strobe_n;
  assign ref_cmd = !row_strobe_n && !col_strobe_n;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Data checks read the latched request, not the live input
  a_write_data_out: assert property (
    (col_cmd && !write_enable_n) |->
    (mem_data_oe && mem_data_out == cur.req.wdata))
    else $error("write data not driven in column phase");
  a_oe_write_only: assert property (
    mem_data_oe |-> (col_cmd && !write_enable_n))
    else $error("data driven outside a write column phase");
  a_page_row_col: assert property (
    row_cmd |=> (col_cmd && $stable(bank0_select_n) &&
    $stable(bank1_select_n)))
    else $error("column phase did not follow row on same bank");
  a_col_after_row: assert property (
    col_cmd |-> $past(row_cmd))
    else $error("column phase without a preceding row phase");
  a_row_geometry: assert property (
    (row_cmd && geometry == GEOM_ROW12) |->
    (mem_addr_bus[9] == cur.req.addr[11] &&
    mem_addr_bus[10] == cur.req.addr[21]))
    else $error("by-16 row mapping wrong");
  a_row_geom_wide: assert property (
    (row_cmd && geometry != GEOM_ROW12) |->
    (mem_addr_bus[9] == cur.req.addr[21] &&
    mem_addr_bus[10] == cur.req.addr[22]))
    else $error("by-32 row mapping wrong");
  a_row_map: assert property (
    row_cmd |-> (mem_addr_bus[7:0] == cur.req.addr[19:12] &&
    mem_addr_bus[8] == cur.req.addr[20] &&
    mem_addr_bus[11] == cur.req.addr[11]))
    else $error("row address mapping wrong");
  a_col_map: assert property (
    col_cmd |-> (mem_addr_bus == {4'h0, cur.req.addr[10:3]}))
    else $error("column address mapping wrong");

  // A request taken beside the pulse delays refresh by two cycles
  a_refresh_issue: assert property (
    refresh_due |-> ##[1:4] (ref_cmd && !bank0_select_n &&
    !bank1_select_n && write_enable_n))
    else $error("auto refresh not issued in time");
  a_refresh_no_data: assert property (
    ref_cmd |-> (write_enable_n && !mem_data_oe))
    else $error("data driven during auto refresh");

  a_bank_decode: assert property (
    row_cmd |-> (bank0_select_n ==
    !({5'h00, cur.req.addr[22:20]} < $past(first_boundary_reg))))
    else $error("bank0 select disagrees with boundary");
  a_bank1_decode: assert property (
    row_cmd |-> (bank1_select_n ==
    !({5'h00, cur.req.addr[22:20]} >= $past(first_boundary_reg) &&
    {5'h00, cur.req.addr[22:20]} < $past(second_boundary_reg))))
    else $error("bank1 select disagrees with boundary");
  a_bank_exclusive: assert property (
    !ref_cmd |-> (bank0_select_n || bank1_select_n))
    else $error("both banks selected outside refresh");
  a_ready_quiet: assert property (
    req_ready |-> (row_strobe_n && col_strobe_n && bank0_select_n &&
    bank1_select_n))
    else $error("memory bus not idle while ready");

  c_write: cover property (col_cmd && !write_enable_n);
  c_read: cover property (col_cmd && write_enable_n);
  c_refresh: cover property (ref_cmd);
  c_unmapped: cover property (row_cmd && bank0_select_n &&
    bank1_select_n);
  c_bank1: cover property (row_cmd && !bank1_select_n);
endmodule : lsad_top
`default_nettype wire

// file: lsad_mem_model.sv
/*
  Behavioural memory devices on two chip selects: record the last row
  and column commands and count auto refresh commands.
  Assumes the strobes come from registers on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module lsad_mem_model (
  input wire logic mclk,
  input wire logic [11:0] addr,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [63:0] dq,
  input wire logic dq_oe,
  output logic [11:0] row,
  output logic [11:0] col,
  output logic [3:0] sel,
  output logic wr,
  output logic [63:0] wd,
  output logic [15:0] refs
);
  logic [15:0] ref_count = 16'h0000;
  assign refs = ref_count;
  always @(posedge mclk) begin
    if (!ras_n && !cas_n && we_n && !cs0_n && !cs1_n) begin
      ref_count <= ref_count + 16'h0001;
    end else if (!ras_n) begin
      row <= addr;
      sel[1:0] <= {cs1_n, cs0_n};
    end else if (!cas_n) begin
      col <= addr;
      sel[3:2] <= {cs1_n, cs0_n};
      wr <= ~we_n;
      // Undriven bus reads back as zero so a stale word cannot match
      wd <= dq_oe ? dq : '0;
    end
  end
endmodule : lsad_mem_model
`default_nettype wire

// file: tb_top.sv
/*
  Self-checking bench for the address decoder: geometry mapping, bank
  selection over the boundary table and auto refresh.
  Assumes lsad_pkg, lsad_top and lsad_mem_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lsad_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  lsad_req_s req = '0;
  logic req_valid = 1'b0;
  logic req_ready, cs0_n, cs1_n, ras_n, cas_n, we_n, oe, wr;
  logic [1:0] geometry = 2'h0;
  logic [7:0] b0 = 8'h08;
  logic [7:0] b1 = 8'h08;
  logic [11:0] ma, row, col;
  logic [63:0] dq, wd;
  logic [3:0] sel;
  logic [15:0] refs;
  int err_count = 0;
  int check_count = 0;
  always #10 mclk = ~mclk;
  lsad_top i_dut (.mclk(mclk), .reset(reset), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .geometry(geometry),
    .first_boundary_reg(b0), .second_boundary_reg(b1),
    .mem_addr_bus(ma), .bank0_select_n(cs0_n), .bank1_select_n(cs1_n),
    .row_strobe_n(ras_n), .col_strobe_n(cas_n), .write_enable_n(we_n),
    .mem_data_out(dq), .mem_data_oe(oe));
  lsad_mem_model i_mem (.mclk(mclk), .addr(ma), .cs0_n(cs0_n),
    .cs1_n(cs1_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .dq(dq),
    .dq_oe(oe), .row(row), .col(col), .sel(sel), .wr(wr), .wd(wd),
    .refs(refs));
  task automatic summarize;
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input string name, input logic [63:0] exp, got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Holds the request until ready is seen, then waits out row and column
  task automatic go(input logic [22:0] a, input logic w);
    int n;
    n = 0;
    req.addr = a;
    req.write = w;
    req.wdata = {a, ~a, a[17:0]};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 40) begin
        chk("req_ready", 64'h1, 64'h0);
        summarize();
      end
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask : go
  task automatic geom_map;
    logic [22:0] a;
    logic [11:0] r;
    a = 23'h4A_B9F8;
    for (int g = 0; g < 3; g++) begin
      geometry = g[1:0];
      go(a, 1'b1);
      r = {a[11], g == 2 ? a[21] : a[22], g == 2 ? a[11] : a[21], a[20:12]};
      chk("row", 64'(r), 64'(row));
      chk("col", 64'({4'h0, a[10:3]}), 64'(col));
      chk("data", {a, ~a, a[17:0]}, wd);
      chk("write", 64'h1, 64'(wr));
    end
  endtask : geom_map
  task automatic bank_map;
    logic [15:0] tbl [8];
    logic [2:0] mb;
    logic [1:0] e;
    tbl = '{16'h0202, 16'h0002, 16'h0204, 16'h0404, 16'h0004, 16'h0408,
      16'h0808, 16'h0008};
    geometry = GEOM_ROW11;
    for (int i = 0; i < 8; i++) begin
      b0 = tbl[i][15:8];
      b1 = tbl[i][7:0];
      for (int m = 1; m < 8; m += 3) begin
        mb = m[2:0];
        go({mb, 20'h0_0000}, 1'b0);
        e = mb < b0 ? 2'b10 : (mb < b1 ? 2'b01 : 2'b11);
        chk("selects", 64'({e, e}), 64'(sel));
        chk("read data", 64'h0, wd);
        chk("read strobe", 64'h0, 64'(wr));
      end
    end
  endtask : bank_map
  // Reset lands while a write is in its row phase
  task automatic reset_check;
    req.addr = 23'h21_0A50;
    req.write = 1'b1;
    req_valid = 1'b1;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    reset = 1'b1;
    chk("row strobe", 64'h0, 64'(ras_n));
    @(posedge mclk);
    #1;
    chk("reset ready", 64'h0, 64'(req_ready));
    chk("reset strobes", 64'h7, 64'({ras_n, cas_n, we_n}));
    chk("reset selects", 64'h3, 64'({cs1_n, cs0_n}));
    chk("reset bus", 64'h0, 64'({oe, ma}));
    reset = 1'b0;
    @(posedge mclk);
    #1;
    chk("ready after reset", 64'h1, 64'(req_ready));
  endtask : reset_check
  // Reads keep coming; the refresh pulse lands in an idle cycle between two of them and the next read waits for it
  task automatic refresh_check;
    int n;
    logic [15:0] r0;
    r0 = refs;
    n = 0;
    geometry = GEOM_ROW11;
    while (refs === r0 && n < 300) begin
      go(23'h12_3458, 1'b0);
      n++;
    end
    chk("refresh", 64'h1, 64'(refs !== r0));
    go(23'h12_3458, 1'b0);
    chk("row after refresh", 64'h123, 64'(row));
    chk("col after refresh", 64'h08B, 64'(col));
  endtask : refresh_check
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    reset = 1'b0;
    geom_map();
    bank_map();
    reset_check();
    refresh_check();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
